// *** pasr_far_model.sv ***
`timescale 1ns/10ps
module pasr_far_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // command
    input  wire logic        start_i,
    input  wire logic [15:0] len_i,
    input  wire logic        slow_i,
    // byte events
    output logic             byte_o,
    output logic             end_o,
    output logic             busy_o
);
    logic [15:0] left_q;
    logic        gap_q;
    // slow mode leaves an idle cycle between bytes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            left_q <= 16'h0000;
            gap_q  <= 1'b0;
            byte_o <= 1'b0;
            end_o  <= 1'b0;
        end
        else
        begin
            byte_o <= 1'b0;
            end_o  <= 1'b0;
            gap_q  <= 1'b0;
            if (start_i)
                left_q <= len_i;
            else if (left_q != 16'h0000 && !gap_q)
            begin
                byte_o <= 1'b1;
                end_o  <= (left_q == 16'h0001);
                left_q <= left_q - 16'h0001;
                gap_q  <= slow_i;
            end
        end
    end
    assign busy_o = (left_q != 16'h0000) || byte_o;
endmodule

// *** pasr_pkg.sv ***
package pasr_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CLK_OFS   = 6'h18;
    localparam logic [5:0] IDX_MISC      = 6'h1B;
    localparam logic [5:0] IDX_IFACE     = 6'h1C;
    localparam logic [5:0] IDX_FIFO_CTL  = 6'h1D;
    localparam logic [5:0] IDX_PKT_CNT   = 6'h1E;
    localparam logic [5:0] IDX_AUX_MODE  = 6'h1E;
    localparam logic [5:0] IDX_SHADOW_EN = 6'h1F;

    // field positions
    localparam int AUX_ABILITY_BIT  = 4;
    localparam int AUX_ISOLATE_BIT  = 3;
    localparam int AUX_ERRCODE_BIT  = 0;
    localparam int SHADOW_EN_BIT    = 7;
    localparam int CLK_FAST_BIT     = 15;
    localparam int CLK_SLOW_BIT     = 14;
    localparam int MISC_MLT3_BIT    = 15;
    localparam int MISC_CABLE_LSB   = 12;
    localparam int MISC_LEDTEST_BIT = 10;
    localparam int MISC_LOCK_BIT    = 9;
    localparam int MISC_LATCH_LSB   = 3;
    localparam int IF_STRAP_LSB     = 10;
    localparam int IF_FLP_BIT       = 7;
    localparam int IF_NLP_BIT       = 6;
    localparam int IF_BREAK_BIT     = 5;
    localparam int IF_FAIL_BIT      = 4;

    // reset values
    localparam logic [15:0] RST_FIFO_CTL = 16'h0000;
    localparam logic [13:0] RST_OFS_RSVD = 14'h0000;
    localparam logic [2:0]  RST_MISC_RSV = 3'h0;
    localparam logic [15:0] RST_PKT_CNT  = 16'h0000;

    // fifo depth in bits = base + step * code
    localparam logic [6:0] FIFO_BASE_BITS = 7'h0C;
    localparam logic [6:0] FIFO_STEP_BITS = 7'h04;

    // delay from negotiation start to ability detect
    localparam int CLK_PERIOD_NS     = 4;
    localparam int ABILITY_DELAY_NS  = 1000;
    localparam int ABILITY_DELAY_CYC = (ABILITY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // strap order: smii, rmii, mii
    localparam int STRAP_MII  = 0;
    localparam int STRAP_SMII = 2;

    typedef enum logic [1:0] {
        PASR_AN_IDLE    = 2'b00,
        PASR_AN_WAIT    = 2'b01,
        PASR_AN_ABILITY = 2'b10,
        PASR_AN_DONE    = 2'b11
    } pasr_an_state_t;

    typedef enum logic [2:0] {
        PASR_SEL_NONE  = 3'b000,
        PASR_SEL_CLK   = 3'b001,
        PASR_SEL_MISC  = 3'b010,
        PASR_SEL_IFACE = 3'b011,
        PASR_SEL_FIFO  = 3'b100,
        PASR_SEL_PKT   = 3'b101,
        PASR_SEL_AUX   = 3'b110,
        PASR_SEL_SHEN  = 3'b111
    } pasr_sel_t;

    typedef struct packed {
        logic       partner_clock_faster;
        logic       partner_clock_slower;
        logic       mlt3_ok;
        logic [2:0] cable_len;
        logic       descr_locked;
        logic [5:0] line_err_ev;
        logic       flp_ev;
        logic       nlp_detect;
        logic       link_break_exp;
        logic       link_fail_exp;
        logic [3:0] fifo_fill;
    } pasr_status_t;

    typedef struct packed {
        logic [3:0] rxd;
        logic       dv;
        logic       er;
    } pasr_mii_rx_t;

    typedef struct packed {
        logic [3:0] txd;
        logic       en;
    } pasr_mii_tx_t;

endpackage

// *** pasr_regs.sv ***
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - ability bit high only in ability detect
// - enter after delay, leave on pulses
// - isolate ignores mii inputs, floats outputs
// - isolate also suppresses link pulses
// - 10M code mode puts error type on rxd
// - clearing bit or reset restores normal
// - no error codes in 10M serial mode
// - 100M always shows error codes
// - shadow enable bit 7 only writable
// - partner clock faster/slower flags
// - mlt3 ok flag bit 15
// - cable length estimate bits 14..12
// - descrambler lock flag bit 9
// - six latching line error flags
// - led test bit 10, resets zero
// - strap interface bits, fifo fill
// - latching flp flag, nlp level flag
// - link break and fail timer flags
// - fifo depth is 12 plus 4*code
// - byte count of last received packet
// - isolate control at aux bit 3
// - ability status at aux bit 4
module pasr_regs #(
    parameter int ABILITY_CYC = pasr_pkg::ABILITY_DELAY_CYC
) (
    // clock and reset
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  RST_N_I,
    // apb slave
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [7:0]            PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    input  wire logic [3:0]            PSTRB_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // datapath status and events
    input  wire pasr_pkg::pasr_status_t STATUS_I,
    input  wire logic [2:0]            STRAP_I,
    input  wire logic                  SPEED_100_I,
    input  wire logic                  AN_BEGIN_I,
    input  wire logic                  RX_BYTE_I,
    input  wire logic                  RX_FRAME_END_I,
    // receive path toward the mac
    input  wire pasr_pkg::pasr_mii_rx_t RX_CORE_I,
    input  wire logic [3:0]            RX_ERR_TYPE_I,
    output pasr_pkg::pasr_mii_rx_t     MII_RX_O,
    output logic                       MII_RX_OE_O,
    // transmit path from the mac
    input  wire pasr_pkg::pasr_mii_tx_t MII_TX_I,
    output pasr_pkg::pasr_mii_tx_t     TX_CORE_O,
    // controls toward the datapath
    output logic                       LINK_PULSE_EN_O,
    output logic                       LED_TEST_O,
    output logic      [6:0]            FIFO_DEPTH_O
);
    import pasr_pkg::*;

    typedef struct packed {
        pasr_an_state_t an_st;
        logic [15:0]    an_cnt;
        logic           ext_isolate;
        logic           err_code_mode;
        logic           shadow_en;
        logic [13:0]    ofs_rsvd;
        logic [2:0]     misc_rsvd;
        logic           led_test;
        logic [5:0]     line_latch;
        logic           flp_latch;
        logic [15:0]    fifo_ctl;
        logic [6:0]     fifo_depth;
        logic [15:0]    pkt_run;
        logic [15:0]    pkt_last;
        logic [2:0]     strap;
        logic           strap_done;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
        pasr_mii_rx_t   rx;
        logic           rx_oe;
        pasr_mii_tx_t   tx;
        logic           link_pulse_en;
    } pasr_state_t;

    pasr_state_t s_q;
    pasr_state_t s_d;

    function automatic pasr_sel_t decode_reg(input logic [7:0] addr, input logic shadow);
        pasr_sel_t sel;
        sel = PASR_SEL_NONE;
        if (addr[1:0] != 2'h0)
            sel = PASR_SEL_NONE;
        else if (addr[7:2] == IDX_SHADOW_EN)
            sel = PASR_SEL_SHEN;
        else if (shadow && addr[7:2] == IDX_CLK_OFS)
            sel = PASR_SEL_CLK;
        else if (shadow && addr[7:2] == IDX_MISC)
            sel = PASR_SEL_MISC;
        else if (shadow && addr[7:2] == IDX_IFACE)
            sel = PASR_SEL_IFACE;
        else if (shadow && addr[7:2] == IDX_FIFO_CTL)
            sel = PASR_SEL_FIFO;
        else if (shadow && addr[7:2] == IDX_PKT_CNT)
            sel = PASR_SEL_PKT;
        else if (!shadow && addr[7:2] == IDX_AUX_MODE)
            sel = PASR_SEL_AUX;
        return sel;
    endfunction

    logic        setup;
    logic        done;
    logic        wr_done;
    pasr_sel_t   sel;
    logic [15:0] wmask;
    logic [15:0] wdat;
    logic [15:0] rd;
    logic        link_seen;
    logic        serial_10;
    logic        code_on;
    logic [15:0] pkt_next;

    always_comb
    begin
        s_d      = s_q;
        setup    = PSEL_I && !PENABLE_I;
        done     = PSEL_I && PENABLE_I && s_q.pready;
        wr_done  = done && PWRITE_I && !s_q.pslverr;
        sel      = decode_reg(PADDR_I, s_q.shadow_en);
        wmask    = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
        wdat     = PWDATA_I[15:0];
        rd       = 16'h0000;
        pkt_next = s_q.pkt_run + {15'h0000, RX_BYTE_I};

        // straps caught once, in the first cycle after reset release
        if (!s_q.strap_done)
        begin
            s_d.strap      = STRAP_I;
            s_d.strap_done = 1'b1;
        end

        // negotiation tracker; a restart wins from any state
        link_seen = STATUS_I.flp_ev || STATUS_I.nlp_detect;
        case (s_q.an_st)
            PASR_AN_IDLE:
                s_d.an_cnt = 16'h0000;
            PASR_AN_WAIT:
                if (s_q.an_cnt >= 16'(ABILITY_CYC - 1))
                    s_d.an_st = PASR_AN_ABILITY;
                else
                    s_d.an_cnt = s_q.an_cnt + 16'h0001;
            PASR_AN_ABILITY:
                if (link_seen)
                    s_d.an_st = PASR_AN_DONE;
            PASR_AN_DONE:
                s_d.an_cnt = 16'h0000;
            default:
                s_d.an_st = PASR_AN_IDLE;
        endcase
        if (AN_BEGIN_I)
        begin
            s_d.an_st  = PASR_AN_WAIT;
            s_d.an_cnt = 16'h0000;
        end

        // read value of the selected register
        case (sel)
            PASR_SEL_CLK:
                rd = {STATUS_I.partner_clock_faster, STATUS_I.partner_clock_slower,
                      s_q.ofs_rsvd};
            PASR_SEL_MISC:
                rd = {STATUS_I.mlt3_ok, STATUS_I.cable_len, 1'b0, s_q.led_test,
                      STATUS_I.descr_locked, s_q.line_latch, s_q.misc_rsvd};
            PASR_SEL_IFACE:
                rd = {3'h0, s_q.strap, 2'h0, s_q.flp_latch, STATUS_I.nlp_detect,
                      STATUS_I.link_break_exp, STATUS_I.link_fail_exp,
                      STATUS_I.fifo_fill};
            PASR_SEL_FIFO:
                rd = s_q.fifo_ctl;
            PASR_SEL_PKT:
                rd = s_q.pkt_last;
            PASR_SEL_AUX:
                rd = {11'h000, (s_q.an_st == PASR_AN_ABILITY), s_q.ext_isolate,
                      2'h0, s_q.err_code_mode};
            PASR_SEL_SHEN:
                rd = {8'h00, s_q.shadow_en, 7'h00};
            default:
                rd = 16'h0000;
        endcase

        // zero wait state: ready raised for the access cycle only
        s_d.pready = setup;
        if (setup)
        begin
            s_d.prdata  = {16'h0000, rd};
            s_d.pslverr = (sel == PASR_SEL_NONE);
        end
        else if (done)
        begin
            s_d.pslverr = 1'b0;
        end

        // writes land at the completing edge
        if (wr_done)
        begin
            case (sel)
                PASR_SEL_CLK:
                    s_d.ofs_rsvd = (s_q.ofs_rsvd & ~wmask[13:0]) | (wdat[13:0] & wmask[13:0]);
                PASR_SEL_MISC:
                begin
                    if (wmask[MISC_LEDTEST_BIT])
                        s_d.led_test = wdat[MISC_LEDTEST_BIT];
                    if (wmask[0])
                        s_d.misc_rsvd = wdat[2:0];
                end
                PASR_SEL_FIFO:
                    s_d.fifo_ctl = (s_q.fifo_ctl & ~wmask) | (wdat & wmask);
                PASR_SEL_AUX:
                    if (wmask[0])
                    begin
                        s_d.ext_isolate   = wdat[AUX_ISOLATE_BIT];
                        s_d.err_code_mode = wdat[AUX_ERRCODE_BIT];
                    end
                PASR_SEL_SHEN:
                    if (wmask[0])
                        s_d.shadow_en = wdat[SHADOW_EN_BIT];
                default:
                    s_d.pkt_last = s_q.pkt_last;
            endcase
        end

        // latched flags clear at the edge that captures the read data,
        // so an event between setup and access is never lost; set wins
        if (setup && !PWRITE_I && sel == PASR_SEL_MISC)
            s_d.line_latch = 6'h00;
        if (setup && !PWRITE_I && sel == PASR_SEL_IFACE)
            s_d.flp_latch = 1'b0;
        s_d.line_latch = s_d.line_latch | STATUS_I.line_err_ev;
        s_d.flp_latch  = s_d.flp_latch | STATUS_I.flp_ev;

        // depth registered so the output comes from a flop
        s_d.fifo_depth = FIFO_BASE_BITS + 7'(s_d.fifo_ctl[3:0]) * FIFO_STEP_BITS;

        // byte counter; the total survives until the next frame end
        if (RX_FRAME_END_I)
        begin
            s_d.pkt_last = pkt_next;
            s_d.pkt_run  = 16'h0000;
        end
        else
        begin
            s_d.pkt_run = pkt_next;
        end

        // receive error signalling
        serial_10 = s_q.strap[STRAP_SMII] && !SPEED_100_I;
        code_on   = SPEED_100_I || (s_q.err_code_mode && !serial_10);
        s_d.rx    = RX_CORE_I;
        if (code_on && RX_CORE_I.dv && RX_CORE_I.er)
        begin
            // a zero type would look like plain data, so force it non-zero
            s_d.rx.rxd = (RX_ERR_TYPE_I == 4'h0) ? 4'h1 : RX_ERR_TYPE_I;
        end
        s_d.tx            = MII_TX_I;
        s_d.rx_oe         = !s_q.ext_isolate;
        s_d.link_pulse_en = !s_q.ext_isolate;
        if (s_q.ext_isolate)
        begin
            s_d.rx = '0;
            s_d.tx = '0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_q          <= '0;
            s_q.an_st    <= PASR_AN_IDLE;
            s_q.ofs_rsvd <= RST_OFS_RSVD;
            s_q.misc_rsvd <= RST_MISC_RSV;
            s_q.fifo_ctl <= RST_FIFO_CTL;
            s_q.fifo_depth <= FIFO_BASE_BITS;
            s_q.pkt_last <= RST_PKT_CNT;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign PRDATA_O        = s_q.prdata;
    assign PREADY_O        = s_q.pready;
    assign PSLVERR_O       = s_q.pslverr;
    assign MII_RX_O        = s_q.rx;
    assign MII_RX_OE_O     = s_q.rx_oe;
    assign TX_CORE_O       = s_q.tx;
    assign LINK_PULSE_EN_O = s_q.link_pulse_en;
    assign LED_TEST_O      = s_q.led_test;
    assign FIFO_DEPTH_O    = s_q.fifo_depth;

    a_ability_exit: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (s_q.an_st == PASR_AN_ABILITY && link_seen && !AN_BEGIN_I)
        |=> s_q.an_st == PASR_AN_DONE)
        else $error("ability state not left on link pulses");

    a_ability_entry: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(s_q.an_st == PASR_AN_ABILITY) |-> $past(s_q.an_st) == PASR_AN_WAIT
        && $past(s_q.an_cnt) == 16'(ABILITY_CYC - 1))
        else $error("ability state entered without full delay");

    a_isolate_mii: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_q.ext_isolate |=> !MII_RX_OE_O && TX_CORE_O == '0 && MII_RX_O == '0)
        else $error("isolate left mii active");

    a_isolate_pulses: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        s_q.ext_isolate ##1 s_q.ext_isolate |-> !LINK_PULSE_EN_O)
        else $error("link pulses not suppressed");

    a_code_fast: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (SPEED_100_I && RX_CORE_I.dv && RX_CORE_I.er && !s_q.ext_isolate)
        |=> MII_RX_O.rxd != 4'h0 && MII_RX_O.er)
        else $error("100M error without type code");

    a_code_serial: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (!SPEED_100_I && s_q.strap[STRAP_SMII] && !s_q.ext_isolate)
        |=> MII_RX_O.rxd == $past(RX_CORE_I.rxd))
        else $error("error code applied in serial mode");

    a_latch_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (s_q.flp_latch && !(setup && !PWRITE_I && sel == PASR_SEL_IFACE))
        |=> s_q.flp_latch)
        else $error("latched flag dropped without read");

    a_latch_set: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        STATUS_I.line_err_ev[0] |=> s_q.line_latch[0])
        else $error("line error event lost");

    a_fifo_depth: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $stable(s_q.fifo_ctl[3:0]) |-> FIFO_DEPTH_O == 7'h0C + 7'(s_q.fifo_ctl[3:0]) * 7'h04)
        else $error("fifo depth mismatch");

    a_pkt_count: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        RX_FRAME_END_I |=> s_q.pkt_last == $past(s_q.pkt_run) + {15'h0000, $past(RX_BYTE_I)}
        && s_q.pkt_run == 16'h0000)
        else $error("packet byte count wrong");

    a_shadow_map: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (setup && !s_q.shadow_en && PADDR_I[7:2] == IDX_CLK_OFS) |=> PSLVERR_O && PREADY_O)
        else $error("shadow offset reachable while disabled");

endmodule

// *** phy_aux_shadow_status_regs_tb.sv ***
`timescale 1ns/10ps
module phy_aux_shadow_status_regs_tb;
    import pasr_pkg::*;
    localparam int ABIL = 4;
    logic         clk = 1'b0, rst_n = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [3:0]   pstrb = 4'h0;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic         pready, pslverr, rx_oe, lp_en, led;
    pasr_status_t st = '0;
    logic [2:0]   strap = 3'h1;
    logic         spd = 1'b0, an_go = 1'b0;
    pasr_mii_rx_t rx_in = '0, rx_out;
    pasr_mii_tx_t tx_in = '0, tx_out;
    logic [3:0]   etype = 4'h0;
    logic [6:0]   depth;
    logic         pkt_go = 1'b0, pkt_slow = 1'b0, rx_byte, rx_end, pkt_busy;
    logic [15:0]  pkt_len = 16'h0, mw = 16'h0;
    int           bad_count = 0, checked = 0;

    always #2 clk = ~clk;

    pasr_regs #(.ABILITY_CYC(ABIL)) dut_u (
        .CORE_CLK_I(clk), .RST_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .STATUS_I(st), .STRAP_I(strap), .SPEED_100_I(spd),
        .AN_BEGIN_I(an_go), .RX_BYTE_I(rx_byte), .RX_FRAME_END_I(rx_end),
        .RX_CORE_I(rx_in), .RX_ERR_TYPE_I(etype), .MII_RX_O(rx_out),
        .MII_RX_OE_O(rx_oe), .MII_TX_I(tx_in), .TX_CORE_O(tx_out),
        .LINK_PULSE_EN_O(lp_en), .LED_TEST_O(led), .FIFO_DEPTH_O(depth)
    );
    pasr_far_model far_u (
        .clk_i(clk), .rst_n_i(rst_n), .start_i(pkt_go), .len_i(pkt_len),
        .slow_i(pkt_slow), .byte_o(rx_byte), .end_o(rx_end), .busy_o(pkt_busy)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= 4'hF;
        @(posedge clk);
        penable <= 1'b1;
        // no cap here: a missing answer is left to the watchdog
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pstrb <= 4'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 16'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask

    // one received nibble, checked at the edge that samples its registered copy
    task automatic rxc(input logic [3:0] d, input logic er, input logic [3:0] t,
                       input logic [3:0] x);
        @(posedge clk);
        rx_in <= {d, 1'b1, er};
        etype <= t;
        repeat (2) @(posedge clk);
        chk({26'h0, rx_out}, {26'h0, x, 1'b1, er});
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [31:0] misc_x(input logic [5:0] ev);
        return {16'h0, st.mlt3_ok, st.cable_len, 1'b0, mw[10], st.descr_locked, ev, mw[2:0]};
    endfunction

    function automatic logic [31:0] if_x(input logic flp);
        return {19'h0, strap, 2'h0, flp, st.nlp_detect, st.link_break_exp,
                st.link_fail_exp, st.fifo_fill};
    endfunction

    initial
    begin
        #200000;
        bad_count++;
        finish_test;
    end

    initial
    begin
        logic [15:0] d;
        logic [5:0]  ev;
        void'($urandom(6758));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h7C, 32'h0);
        rd(8'h78, 32'h0);
        chk(32'(depth), 32'd12);
        chk({31'h0, led}, 32'h0);
        rd(8'h40, 32'h0, 1'b1);
        rd(8'h60, 32'h0, 1'b1);
        wr(8'h7C, 16'hFFFF);
        rd(8'h7C, 32'h80);
        rd(8'h60, 32'h0);
        rd(8'h6C, 32'h0);
        rd(8'h70, if_x(1'b0));
        rd(8'h78, 32'h0);
        // listed size codes only
        for (int c = 0; c < 14; c++)
        begin
            d = 16'($urandom());
            d[3:0] = c[3:0];
            wr(8'h74, d);
            repeat (3) @(posedge clk);
            chk(32'(depth), 32'(12 + 4 * c));
            rd(8'h74, {16'h0, d});
        end
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            st.cable_len <= i[2:0];
            {st.mlt3_ok, st.descr_locked} <= 2'($urandom());
            {st.partner_clock_faster, st.partner_clock_slower} <= i[1:0];
            mw = 16'($urandom());
            d = 16'($urandom());
            wr(8'h6C, mw);
            wr(8'h60, d);
            rd(8'h6C, misc_x(6'h0));
            rd(8'h60, {16'h0, i[1:0], d[13:0]});
            chk({31'h0, led}, {31'h0, mw[10]});
            ev = 6'($urandom()) | (6'h01 << (i % 6));
            st.line_err_ev <= ev;
            @(posedge clk);
            st.line_err_ev <= 6'h0;
            rd(8'h6C, misc_x(ev));
            rd(8'h6C, misc_x(6'h0));
            {st.nlp_detect, st.link_break_exp, st.link_fail_exp, st.fifo_fill} <= 7'($urandom());
            st.flp_ev <= 1'b1;
            @(posedge clk);
            st.flp_ev <= 1'b0;
            rd(8'h70, if_x(1'b1));
            rd(8'h70, if_x(1'b0));
        end
        for (int k = 0; k < 3; k++)
        begin
            d = 16'($urandom_range(300, 1));
            pkt_len <= d;
            pkt_slow <= k[0];
            pkt_go <= 1'b1;
            @(posedge clk);
            pkt_go <= 1'b0;
            for (int n = 0; n < 2000 && (pkt_busy || n < 2); n++)
                @(posedge clk);
            rd(8'h78, {16'h0, d});
        end
        wr(8'h7C, 16'h0);
        tx_in <= 5'($urandom()) | 5'h01;
        wr(8'h78, 16'h0008);
        rd(8'h78, 32'h8);
        repeat (3) @(posedge clk);
        chk({31'h0, rx_oe}, 32'h0);
        chk({27'h0, tx_out}, 32'h0);
        chk({31'h0, lp_en}, 32'h0);
        wr(8'h78, 16'h0001);
        repeat (3) @(posedge clk);
        chk({31'h0, rx_oe}, 32'h1);
        chk({31'h0, lp_en}, 32'h1);
        chk({27'h0, tx_out}, {27'h0, tx_in});
        for (int k = 0; k < 4; k++)
        begin
            ev = 6'($urandom());
            d[3:0] = 4'($urandom()) | 4'h1;
            rxc(ev[3:0], 1'b1, d[3:0], d[3:0]);
            rxc(ev[3:0], 1'b0, d[3:0], ev[3:0]);
        end
        rxc(4'h5, 1'b1, 4'h0, 4'h1);
        wr(8'h78, 16'h0);
        repeat (2) @(posedge clk);
        rxc(4'h5, 1'b1, 4'h9, 4'h5);
        spd <= 1'b1;
        rxc(4'h5, 1'b1, 4'h9, 4'h9);
        spd <= 1'b0;
        st.nlp_detect <= 1'b0;
        an_go <= 1'b1;
        @(posedge clk);
        an_go <= 1'b0;
        rd(8'h78, 32'h0);
        repeat (ABIL + 4) @(posedge clk);
        rd(8'h78, 32'h10);
        st.flp_ev <= 1'b1;
        @(posedge clk);
        st.flp_ev <= 1'b0;
        rd(8'h78, 32'h0);
        wr(8'h78, 16'h0001);
        // serial strap only takes effect through a reset
        strap <= 3'h4;
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h78, 32'h0);
        wr(8'h78, 16'h0001);
        repeat (2) @(posedge clk);
        rxc(4'h6, 1'b1, 4'h9, 4'h6);
        finish_test;
    end
endmodule
